//--- core/sac_pkg.sv
// Constants and state types shared by the converter control block
package sac_pkg;

  // Result width and ladder size
  localparam int          DATA_W        = 8;
  localparam int          LADDER_TAPS   = 256;
  localparam int          STEPS         = 8;

  // Sequencing: one bit decision per group of clock periods
  localparam int          CLK_PER_STEP  = 8;
  localparam int          CONV_CLKS     = STEPS * CLK_PER_STEP;
  localparam int          PHASE_W       = 3;
  localparam logic [2:0]  PHASE_LAST    = 3'(CLK_PER_STEP - 1);

  // Clock
  localparam int          CLK_PERIOD_PS = 5000;

  // Search start values and full scale
  localparam logic [7:0]  SEQ_FIRST     = 8'h80;
  localparam logic [7:0]  SAR_MSB       = 8'h80;
  localparam logic [7:0]  FULL_SCALE    = 8'hff;

  // Reset values
  localparam logic [7:0]  CODE_RST      = 8'h00;
  localparam logic [7:0]  SEQ_RST       = 8'h00;
  localparam logic        STROBE_RST    = 1'b1;
  localparam logic        DONE_N_RST    = 1'b1;
  localparam logic        FLAG_RST      = 1'b0;
  localparam logic [2:0]  PHASE_RST     = 3'h0;

  typedef struct packed {
    logic             sel_n_d;
    logic             start_n_d;
    logic             done_flag_n;
    logic             data_oe;
    logic [7:0]       data_out;
    logic [7:0]       tap;
  } sac_top_s;

  typedef struct packed {
    logic             start_ff;
    logic             start_q;
    logic [2:0]       phase;
  } sac_start_s;

  typedef struct packed {
    logic [7:0]       seq;
    logic [7:0]       sar;
    logic             finish;
  } sac_sar_s;

  localparam sac_top_s   TOP_RST   = '{sel_n_d: STROBE_RST, start_n_d: STROBE_RST, done_flag_n: DONE_N_RST,
                                       data_oe: FLAG_RST, data_out: CODE_RST, tap: CODE_RST};
  localparam sac_start_s START_RST = '{start_ff: FLAG_RST, start_q: FLAG_RST, phase: PHASE_RST};
  localparam sac_sar_s   SAR_RST   = '{seq: SEQ_RST, sar: CODE_RST, finish: FLAG_RST};

endpackage

//--- core/sac_conv_if.sv
// Internal link between strobe control, start sequencer and approximation register
`timescale 1ns/1ps
interface sac_conv_if;
  logic       hold;     // Select and start both low
  logic       clear;    // Reset sequencer and register
  logic       comp_ge;  // Input at or above trial level
  logic       launch;   // Shift the marker one in
  logic       step_end; // Last clock of a decision step
  logic [7:0] trial;    // Current trial code
  logic [7:0] result;   // Finished code
  logic       finish;   // Marker has left the sequencer
  logic       busy;     // Search running

  modport top   (output hold, clear, comp_ge, input launch, step_end, trial, result, finish, busy);
  modport start (input hold, output launch, step_end);
  modport sar   (input clear, comp_ge, launch, step_end, output trial, result, finish, busy);
endinterface

//--- core/sac_start.sv
// Start flip-flop and free-running step phase divider
`timescale 1ns/1ps
module sac_start (
  input  wire logic clk,      // Conversion clock
  input  wire logic reset_n,  // Synchronous reset, active low
  sac_conv_if.start cv        // Link to control and register
);
  import sac_pkg::*;

  sac_start_s st;
  sac_start_s next_st;

  assign cv.step_end = (st.phase == PHASE_LAST);
  // Launch waits for the phase boundary, so start lands 1 to 8 clocks after release
  assign cv.launch   = st.start_ff && st.start_q && !cv.hold && cv.step_end; // [R11] [R12]

  always_comb begin
    next_st       = st;
    next_st.phase = st.phase + 3'h1;
    next_st.start_q = st.start_ff; // [R11]
    if (cv.hold) begin
      next_st.start_ff = 1'b1; // [R10]
    end else if (cv.launch) begin
      next_st.start_ff = 1'b0; // [R11]
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st <= START_RST;
    end else begin
      st <= next_st;
    end
  end

  a_step_period: assert property (@(posedge clk) disable iff (!reset_n) // [R2]
    cv.step_end |=> (!cv.step_end)[*7] ##1 cv.step_end)
    else $error("step boundary not every eight clocks");

  a_start_clears: assert property (@(posedge clk) disable iff (!reset_n) // [R11]
    cv.launch |=> !st.start_ff)
    else $error("start flip-flop not cleared after launch");

endmodule // sac_start

//--- core/sac_sar.sv
// Marker shift register and successive-approximation register
`timescale 1ns/1ps
module sac_sar (
  input  wire logic clk,      // Conversion clock
  input  wire logic reset_n,  // Synchronous reset, active low
  sac_conv_if.sar   cv        // Link to control and start logic
);
  import sac_pkg::*;

  sac_sar_s   st;
  sac_sar_s   next_st;
  logic [7:0] dec;
  logic [7:0] next_mark;

  assign next_mark = st.seq >> 1;

  // Bit under test takes the comparison; the next lower bit becomes the new trial one
  genvar i;
  generate
    for (i = 0; i < DATA_W; i++) begin : g_bit
      assign dec[i] = st.seq[i] ? cv.comp_ge : (st.sar[i] | next_mark[i]); // [R1]
    end
  endgenerate

  assign cv.trial  = st.sar;  // [R4]
  assign cv.result = st.sar;  // [R3]
  assign cv.busy   = |st.seq;
  assign cv.finish = st.finish;

  always_comb begin
    next_st        = st;
    next_st.finish = 1'b0;
    if (cv.clear) begin
      next_st.seq = SEQ_RST; // [R8] [R9]
      next_st.sar = CODE_RST; // [R8]
    end else if (cv.launch) begin
      next_st.seq = SEQ_FIRST; // [R11]
      next_st.sar = SAR_MSB; // [R1]
    end else if (cv.step_end && cv.busy) begin
      next_st.sar    = dec;
      next_st.seq    = next_mark;
      next_st.finish = st.seq[0]; // [R13]
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st <= SAR_RST;
    end else begin
      st <= next_st;
    end
  end

  a_lsb_decide: assert property (@(posedge clk) disable iff (!reset_n) // [R1]
    (cv.step_end && st.seq == 8'h01 && !cv.clear) |=> (st.sar[0] == $past(cv.comp_ge)) && cv.finish)
    else $error("last bit decision wrong");

  a_msb_decide: assert property (@(posedge clk) disable iff (!reset_n) // [R1]
    (cv.step_end && st.seq == SEQ_FIRST && !cv.clear && !cv.launch)
      |=> (st.sar[7] == $past(cv.comp_ge)) && st.sar[6] && st.seq == 8'h40)
    else $error("top bit decision or next trial wrong");

endmodule // sac_sar

//--- core/sac_adc_ctl.sv
// Bus-facing control of the 8-bit successive-approximation converter
`timescale 1ns/1ps

// Overview of operation
// R1: Search tests top bit first; bit is one when input at or above trial.
// R2: Eight decisions take 64 clocks; code latched and done flag driven low.
// R3: Code is straight binary; all ones means full-scale input.
// R4: Trial level is a tap of a 256-step ladder matching the differential input.
// R5: Host ties done flag to start and holds select low to free-run.
// R6: Host holds start low during power-up to reach a known state.
// R7: Select falling at any time aborts a running conversion.
// R8: Start falling clears the approximation register and marker shift register.
// R9: While select and start are both low the converter stays in reset.
// R10: Select and start low set start flip-flop, clear done and shift register.
// R11: Start flip-flop output rises next clock; launch clears it and shifts one in.
// R12: Conversion begins one to eight clocks after select or start rises.
// R13: Marker leaving the shift register loads the latch and sets done next clock.
// R14: Done flag output is inverse of done flip-flop: high converting, low done.
// R15: Select and output enable low drive the result and clear done flip-flop.
// R16: Select or output enable high floats the data and keeps done cleared.
// R17: Conversion clock comes from an external source or on-chip RC oscillator.
// R18: Latch keeps the previous result during conversion; updates only at completion.
module sac_adc_ctl (
  input  wire logic                          clk,         // Conversion clock, external or RC oscillator
  input  wire logic                          reset_n,     // Synchronous reset, active low
  input  wire logic                          sel_n,       // Chip select, active low
  input  wire logic                          start_n,     // Start strobe, active low
  input  wire logic                          oe_n,        // Output enable strobe, active low
  input  wire logic                          in_ge,       // Comparator: input at or above tap
  output logic      [sac_pkg::DATA_W-1:0]    ladder_tap,  // Ladder tap select for the trial
  output logic      [sac_pkg::DATA_W-1:0]    data_out,    // Latched result, bits 0 to 7
  output logic                               data_oe,     // Data driver enable, high drives
  output logic                               done_flag_n  // Done flag, low when result ready
);
  import sac_pkg::*;

  // The clock port serves either clock source alike [R17]
  sac_top_s   st;
  sac_top_s   next_st;
  logic       rd_req;
  logic       start_fall;
  logic       sel_fall;

  sac_conv_if cv ();

  sac_start u_start (
    .clk     (clk),
    .reset_n (reset_n),
    .cv      (cv.start)
  );

  sac_sar u_sar (
    .clk     (clk),
    .reset_n (reset_n),
    .cv      (cv.sar)
  );

  assign rd_req     = !sel_n && !oe_n;
  assign start_fall = st.start_n_d && !start_n;
  assign sel_fall   = st.sel_n_d && !sel_n;

  // Power-up start-low from the host lands here as a hold only while select is also low [R6]
  assign cv.hold    = !sel_n && !start_n; // [R9] [R10]
  assign cv.clear   = cv.hold || start_fall || sel_fall; // [R7] [R8] [R9]
  assign cv.comp_ge = in_ge; // [R4]

  always_comb begin
    next_st           = st;
    next_st.sel_n_d   = sel_n;
    next_st.start_n_d = start_n;
    // Tap follows the trial one clock late; the comparison is sampled at the step end
    next_st.tap       = cv.trial; // [R4]
    next_st.data_oe   = rd_req; // [R15] [R16]
    if (rd_req || cv.hold) begin
      next_st.done_flag_n = 1'b1; // [R10] [R15] [R16]
    end
    // Completion wins over a clear in the same clock so the event is not lost
    if (cv.finish) begin
      next_st.data_out    = cv.result; // [R13] [R18]
      next_st.done_flag_n = 1'b0; // [R13] [R14] [R2]
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st <= TOP_RST;
    end else begin
      st <= next_st;
    end
  end

  assign ladder_tap  = st.tap;
  assign data_out    = st.data_out;
  assign data_oe     = st.data_oe;
  assign done_flag_n = st.done_flag_n; // [R14]

  // Free-running use: done tied to start with select low re-arms through a hold [R5]

  // Helper: clocks since launch, saturating
  localparam int RUN_CNT_W = 8;
  localparam int RUN_DONE  = CONV_CLKS + 1;
  logic [RUN_CNT_W-1:0] run_cnt;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      run_cnt <= '0;
    end else if (cv.launch && !cv.clear) begin
      run_cnt <= 8'h01;
    end else if (run_cnt != 8'hff) begin
      run_cnt <= run_cnt + 8'h01;
    end
  end

  sequence s_release;
    cv.hold [*2] ##1 !cv.hold;
  endsequence

  sequence s_read;
    !sel_n && !oe_n && !cv.finish;
  endsequence

  sequence s_completion;
    cv.finish ##1 !done_flag_n;
  endsequence

  a_msb_first: assert property (@(posedge clk) disable iff (!reset_n) // [R1]
    $rose(cv.busy) |-> cv.trial == SAR_MSB)
    else $error("search did not start at the top bit");

  a_conv_length: assert property (@(posedge clk) disable iff (!reset_n) // [R2]
    cv.finish |-> run_cnt == RUN_DONE[RUN_CNT_W-1:0])
    else $error("conversion did not take 64 clocks");

  a_done_set: assert property (@(posedge clk) disable iff (!reset_n) // [R13]
    cv.finish |-> s_completion)
    else $error("done flag not low the clock after completion");

  a_result_latch: assert property (@(posedge clk) disable iff (!reset_n) // [R13]
    cv.finish |=> data_out == $past(cv.result))
    else $error("result not loaded into the output latch");

  a_latch_holds: assert property (@(posedge clk) disable iff (!reset_n) // [R18]
    !cv.finish |=> $stable(data_out))
    else $error("output latch changed outside completion");

  a_full_scale: assert property (@(posedge clk) disable iff (!reset_n) // [R3]
    (cv.finish && cv.result == FULL_SCALE) |=> data_out == FULL_SCALE)
    else $error("full-scale code not latched as all ones");

  a_hold_reset: assert property (@(posedge clk) disable iff (!reset_n) // [R9]
    (cv.hold && !cv.finish) |=> done_flag_n && !cv.busy)
    else $error("converter not held in reset");

  a_start_clear: assert property (@(posedge clk) disable iff (!reset_n) // [R8]
    start_fall |=> cv.trial == CODE_RST && !cv.busy)
    else $error("start strobe fall did not clear the register");

  a_select_abort: assert property (@(posedge clk) disable iff (!reset_n) // [R7]
    sel_fall |=> !cv.busy && !cv.finish)
    else $error("select fall did not abort the conversion");

  a_begin_window: assert property (@(posedge clk) disable iff (!reset_n) // [R12]
    s_release |-> ##[0:7] (cv.launch || cv.hold))
    else $error("conversion did not begin within eight clocks");

  a_launch_busy: assert property (@(posedge clk) disable iff (!reset_n) // [R11]
    (cv.launch && !cv.clear) |=> cv.busy ##1 !cv.launch)
    else $error("launch did not start the marker");

  a_read_drive: assert property (@(posedge clk) disable iff (!reset_n) // [R15]
    s_read |=> data_oe && done_flag_n)
    else $error("read did not drive data or clear done");

  a_read_float: assert property (@(posedge clk) disable iff (!reset_n) // [R16]
    (sel_n || oe_n) |=> !data_oe)
    else $error("data driven without select and output enable");

  a_done_stays: assert property (@(posedge clk) disable iff (!reset_n) // [R16]
    (done_flag_n && !cv.finish) |=> done_flag_n)
    else $error("done flag fell without completion");

  a_done_inverse: assert property (@(posedge clk) disable iff (!reset_n) // [R14]
    (cv.busy && !cv.finish && done_flag_n) |=> done_flag_n)
    else $error("done flag low while converting");

  a_tap_follow: assert property (@(posedge clk) disable iff (!reset_n) // [R4]
    1'b1 |=> ladder_tap == $past(cv.trial))
    else $error("ladder tap does not follow the trial code");

endmodule // sac_adc_ctl

//--- tb/sac_bus_model.sv
// Host-side model: differential analog source, comparator and data bus resolution
`timescale 1ns/1ps
module sac_bus_model (
  input  wire logic                        clk,         // Conversion clock
  input  wire logic [sac_pkg::DATA_W-1:0]  vin_pos,     // Positive analog input, in ladder steps
  input  wire logic [sac_pkg::DATA_W-1:0]  vin_neg,     // Negative analog input, in ladder steps
  input  wire logic [sac_pkg::DATA_W-1:0]  ladder_tap,  // Trial tap from the converter
  input  wire logic [sac_pkg::DATA_W-1:0]  data_out,    // Converter data drivers
  input  wire logic                        data_oe,     // Converter driver enable
  output logic                             in_ge,       // Comparator result
  output logic      [sac_pkg::DATA_W-1:0]  bus          // Resolved data bus
);
  import sac_pkg::*;
  logic [DATA_W-1:0] last = '0;
  // A negative difference reads as zero
  assign in_ge = ((vin_pos > vin_neg) ? (vin_pos - vin_neg) : '0) >= ladder_tap;
  always @(posedge clk) begin
    if (data_oe) begin
      last <= data_out;
    end
  end
  // Floating bus shows the inverse of the last driven value, never a stale match
  assign bus = data_oe ? data_out : ~last;
endmodule // sac_bus_model

//--- tb/tb_sac_adc_ctl.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module tb_sac_adc_ctl;
  import sac_pkg::*;
  localparam logic [15:0] CORNERS [5] = '{16'h0000, 16'hff00, 16'h8000, 16'h7f00, 16'h1020};
  logic              clk = 1'b0;
  logic              reset_n = 1'b0;
  logic              sel_n = 1'b1;
  logic              start_n = 1'b0;
  logic              oe_n = 1'b1;
  logic              free_run = 1'b0;
  logic              done_seen;
  logic              in_ge, data_oe, done_flag_n;
  logic [7:0]        vin_pos = 8'h00;
  logic [7:0]        vin_neg = 8'h00;
  logic [7:0]        ladder_tap, data_out, bus, p, m, prev;
  int                err_count = 0;
  int                total_checks = 0;
  int                seed = 38;
  int                n;

  always #2.5 clk = ~clk;

  sac_adc_ctl u_dut (
    .clk         (clk),
    .reset_n     (reset_n),
    .sel_n       (sel_n),
    .start_n     (start_n),
    .oe_n        (oe_n),
    .in_ge       (in_ge),
    .ladder_tap  (ladder_tap),
    .data_out    (data_out),
    .data_oe     (data_oe),
    .done_flag_n (done_flag_n)
  );

  sac_bus_model u_host (
    .clk        (clk),
    .vin_pos    (vin_pos),
    .vin_neg    (vin_neg),
    .ladder_tap (ladder_tap),
    .data_out   (data_out),
    .data_oe    (data_oe),
    .in_ge      (in_ge),
    .bus        (bus)
  );

  // Host loop for free-running conversions
  always @(posedge clk) begin
    if (free_run) begin
      start_n <= done_flag_n;
    end
  end

  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [7:0] expect_code(logic [7:0] pp, logic [7:0] mm);
    logic [7:0] d;
    logic [7:0] c;
    d = (pp > mm) ? (pp - mm) : 8'h00;
    c = 8'h00;
    for (int b = 7; b >= 0; b--) begin
      if (d >= (c | (8'h01 << b))) begin
        c = c | (8'h01 << b);
      end
    end
    return c;
  endfunction

  task automatic start_conv(logic [7:0] pp, logic [7:0] mm);
    @(posedge clk);
    vin_pos <= pp;
    vin_neg <= mm;
    sel_n   <= 1'b0;
    start_n <= 1'b0;
    repeat (2) @(posedge clk);
    start_n <= 1'b1;
  endtask

  task automatic wait_done(output int k);
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (done_flag_n !== 1'b0 && k < 100);
  endtask

  task automatic run_conv(logic [7:0] pp, logic [7:0] mm);
    start_conv(pp, mm);
    @(posedge clk);
    #1;
    check("busy flag", 8'h01, done_flag_n);
    wait_done(n);
    check("done latency", 8'h01, n >= 65 && n <= 72);
  endtask

  task automatic read_check(logic [7:0] exp);
    @(posedge clk);
    oe_n <= 1'b0;
    @(posedge clk);
    #1;
    check("read drive", 8'h01, data_oe);
    check("read data", exp, bus);
    check("read clears done", 8'h01, done_flag_n);
    @(posedge clk);
    oe_n <= 1'b1;
    @(posedge clk);
    #1;
    check("bus released", 8'h00, data_oe);
    check("done stays clear", 8'h01, done_flag_n);
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    err_count++;
    close_out();
  end

  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    start_n <= 1'b1;
    @(posedge clk);
    #1;
    check("reset done flag", 8'h01, done_flag_n);
    check("reset drive", 8'h00, data_oe);
    // Corner levels first, then random ones
    for (int i = 0; i < 12; i++) begin
      if (i < 5) begin
        p = CORNERS[i][15:8];
        m = CORNERS[i][7:0];
      end else begin
        p = 8'($random(seed));
        m = 8'($random(seed)) & 8'h3f;
      end
      run_conv(p, m);
      prev = expect_code(p, m);
      read_check(prev);
    end
    // Long hold keeps the converter reset, then starts late
    run_conv(8'h5a, 8'h00);
    @(posedge clk);
    start_n <= 1'b0;
    repeat (30) @(posedge clk);
    #1;
    check("hold clears done", 8'h01, done_flag_n);
    check("hold keeps search idle", 8'h00, ladder_tap);
    @(posedge clk);
    start_n <= 1'b1;
    wait_done(n);
    check("late start latency", 8'h01, n >= 66 && n <= 73);
    prev = 8'h5a;
    read_check(prev);
    // Read mid-conversion sees the old code, then select aborts
    start_conv(8'hc3, 8'h00);
    repeat (20) @(posedge clk);
    read_check(prev);
    @(posedge clk);
    sel_n <= 1'b1;
    @(posedge clk);
    sel_n <= 1'b0;
    wait_done(n);
    check("select abort", 8'h01, n == 100);
    // Start strobe falling with select high clears the search
    start_conv(8'h3c, 8'h00);
    repeat (20) @(posedge clk);
    sel_n   <= 1'b1;
    start_n <= 1'b0;
    @(posedge clk);
    start_n <= 1'b1;
    wait_done(n);
    check("start abort", 8'h01, n == 100);
    @(posedge clk);
    sel_n <= 1'b0;
    read_check(prev);
    // Free-running loop with done fed back to start
    start_conv(8'h99, 8'h00);
    free_run  <= 1'b1;
    n         = 0;
    done_seen = 1'b1;
    repeat (240) begin
      @(posedge clk);
      #1;
      if (done_flag_n === 1'b0 && done_seen === 1'b1) begin
        n++;
      end
      done_seen = done_flag_n;
    end
    check("free run completions", 8'h01, n >= 2 && n <= 3);
    @(posedge clk);
    free_run <= 1'b0;
    @(posedge clk);
    start_n <= 1'b1;
    run_conv(8'h01, 8'h00);
    read_check(8'h01);
    close_out();
  end
endmodule // tb_sac_adc_ctl
